//--- hdl/sat_uart.v
// Purpose: Asynchronous serial transmitter and receiver, minimal or enhanced form.
// Assumes: All inputs are synchronous to clk (40 MHz); the serial line idles high.
// Notes:   ENHANCED=0 gives the fixed divisor, no-parity form; 1 adds run-time
//          divisor and parity. Divisors below six are not supported.
`timescale 1ns/1ps
`include "sat_defines.vh"

module sat_uart (
  clk,
  arst_n,
  baudDiv,
  parityEnable,
  parityOdd,
  twoStopBits,
  txWrite,
  txByte,
  txIdle,
  txd,
  rxd,
  rxRead,
  rxData,
  rxValid,
  rxOverrun,
  frameError,
  parityError
);
  parameter ENHANCED = 1;

  input  wire                   clk;
  input  wire                   arst_n;
  input  wire [`SAT_DIV_W-1:0]  baudDiv;
  input  wire                   parityEnable;
  input  wire                   parityOdd;
  input  wire                   twoStopBits;
  input  wire                   txWrite;
  input  wire [`SAT_DATA_W-1:0] txByte;
  output reg                    txIdle;
  output wire                   txd;
  input  wire                   rxd;
  input  wire                   rxRead;
  output wire [`SAT_DATA_W-1:0] rxData;
  output wire                   rxValid;
  output wire                   rxOverrun;
  output wire                   frameError;
  output wire                   parityError;

  // Parity bit that completes the data to the selected even or odd count.
  function parity_bit;
    input [`SAT_DATA_W-1:0] data;
    input                   odd;
    begin
      parity_bit = (^data) ^ odd;
    end
  endfunction

  wire [`SAT_DIV_W-1:0] divisor;
  wire                  parOn;

  generate
    if (ENHANCED != 0) begin : g_enh
      assign divisor = baudDiv;
      assign parOn   = parityEnable;
    end else begin : g_min
      // The minimal form ignores baudDiv and parityEnable; twoStopBits still lengthens the transmit frame.
      assign divisor = `SAT_DIV_FIXED;
      assign parOn   = 1'b0;
    end
  endgenerate

  // ---------------- Transmitter ----------------
  reg  [`SAT_TXSR_W-1:0]  txShift_q;
  reg  [`SAT_TXSR_W-1:0]  txShift_d;
  reg  [`SAT_TXCNT_W-1:0] txCount_q;
  reg  [`SAT_TXCNT_W-1:0] txCount_d;
  wire                    txTick;
  wire [`SAT_TXCNT_W-1:0] txLoad;

  sat_baud_counter u_tx_baud (
    .clk      (clk),
    .arst_n   (arst_n),
    .divisor  (divisor),
    .restart  (txWrite),
    .terminal (txTick),
    .midpoint ()
  );

  // Ten for start+data+stop, one more per extra stop and per parity bit.
  assign txLoad = `SAT_TXCNT_BASE + {3'h0, twoStopBits} + {3'h0, parOn};

  always @* begin
    txShift_d = txShift_q;
    txCount_d = txCount_q;
    if (txWrite) begin
      // A write while busy aborts the frame in flight: there is no holding register.
      txShift_d = {parity_bit(txByte, parityOdd), txByte, 1'b0};
      txCount_d = txLoad;
    end else if (txTick && (txCount_q != 4'h0)) begin
      // Parity stage feeds the data stages only when parity is on.
      txShift_d = {1'b1, (parOn ? txShift_q[`SAT_TXSR_W-1] : 1'b1),
                   txShift_q[`SAT_TXSR_W-2:1]};
      txCount_d = txCount_q - 4'h1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift_q <= `SAT_TXSR_RST;
      txCount_q <= 4'h0;
      txIdle    <= 1'b1;
    end else begin
      txShift_q <= txShift_d;
      txCount_q <= txCount_d;
      txIdle    <= (txCount_d == 4'h0);
    end
  end

  // Stage zero drives the line; it holds one between frames.
  assign txd = txShift_q[0];

  // ---------------- Receiver ----------------
  reg                    rxLine_q;
  reg                    rxLinePrev_q;
  reg  [`SAT_RXSR_W-1:0] rxShift_q;
  reg  [`SAT_RXSR_W-1:0] rxShift_d;
  reg                    rxStore;
  reg  [`SAT_DATA_W-1:0] rxStoreData;
  reg                    rxStoreStop;
  reg                    rxStoreParErr;
  wire                   rxEdge;
  wire                   rxSample;

  assign rxEdge = rxLine_q ^ rxLinePrev_q;

  sat_baud_counter u_rx_baud (
    .clk      (clk),
    .arst_n   (arst_n),
    .divisor  (divisor),
    .restart  (rxEdge),
    .terminal (),
    .midpoint (rxSample)
  );

  always @* begin
    rxShift_d     = rxShift_q;
    rxStore       = 1'b0;
    rxStoreData   = rxShift_q[`SAT_DATA_W:1];
    rxStoreStop   = parOn ? rxShift_q[`SAT_RXSR_TOP] : rxShift_q[`SAT_RXSR_PAR];
    rxStoreParErr = parOn &&
                    (parity_bit(rxShift_q[`SAT_DATA_W:1], parityOdd) != rxShift_q[`SAT_RXSR_PAR]);
    if (!rxShift_q[0]) begin
      // Start bit reached the lowest stage: frame complete.
      rxStore   = 1'b1;
      rxShift_d = `SAT_RXSR_RST;
    end else if (rxSample && !rxEdge) begin
      // A sample in the cycle that sees the start edge comes before the restart and would take the start bit twice.
      if (parOn) begin
        rxShift_d = {rxLine_q, rxShift_q[`SAT_RXSR_W-1:1]};
      end else begin
        // Enter at the parity stage, bypassing the stop stage, so that the stop bit lands next to the data.
        rxShift_d = {1'b1, rxLine_q, rxShift_q[`SAT_RXSR_PAR:1]};
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxLine_q     <= 1'b1;
      rxLinePrev_q <= 1'b1;
      rxShift_q    <= `SAT_RXSR_RST;
    end else begin
      rxLine_q     <= rxd;
      rxLinePrev_q <= rxLine_q;
      rxShift_q    <= rxShift_d;
    end
  end

  sat_rx_buffer u_rx_buf (
    .clk         (clk),
    .arst_n      (arst_n),
    .store       (rxStore),
    .storeData   (rxStoreData),
    .storeStop   (rxStoreStop),
    .storeParErr (rxStoreParErr),
    .readStrobe  (rxRead),
    .rxData      (rxData),
    .rxValid     (rxValid),
    .rxOverrun   (rxOverrun),
    .frameError  (frameError),
    .parityError (parityError)
  );
endmodule // sat_uart

//--- hdl/sat_defines.vh
// Purpose: Shared constants of the serial asynchronous transceiver.
// Assumes: Included by bare name from every design file of the block.
// Notes:   Definitions only.
`ifndef SAT_DEFINES_VH
`define SAT_DEFINES_VH

// Width of the run-time divisor input and of both baud counters.
`define SAT_DIV_W        12
// Synthesis-time divisor used by the minimal form.
`define SAT_DIV_FIXED    12'h0d9
// Smallest divisor that keeps the midpoint strobe clear of the restart.
`define SAT_DIV_MIN      12'h006

// Data bits per frame.
`define SAT_DATA_W       8
// Transmit shift register: parity stage, 8 data bits, start bit.
`define SAT_TXSR_W       10
// Bit counter load for one stop bit and no parity.
`define SAT_TXCNT_BASE   4'ha
`define SAT_TXCNT_W      4

// Receive shift register: stop, parity, 8 data bits, start bit.
`define SAT_RXSR_W       11
`define SAT_RXSR_PAR     9
`define SAT_RXSR_TOP     10

// Reset values.
`define SAT_TXSR_RST     10'h3ff
`define SAT_RXSR_RST     11'h7ff
`define SAT_DIV_RST      12'h000

`endif

//--- hdl/sat_baud_counter.v
// Purpose: Baud counter that ticks once per bit period, with no prescaler.
// Assumes: divisor is at least six; it may change at any time.
// Notes:   Counts 0 .. divisor-1; restart forces the count back to zero.
`timescale 1ns/1ps
`include "sat_defines.vh"

module sat_baud_counter (
  clk,
  arst_n,
  divisor,
  restart,
  terminal,
  midpoint
);
  input  wire                  clk;
  input  wire                  arst_n;
  input  wire [`SAT_DIV_W-1:0] divisor;
  input  wire                  restart;
  output wire                  terminal;
  output wire                  midpoint;

  reg  [`SAT_DIV_W-1:0] count_q;
  wire [`SAT_DIV_W-1:0] lastCount;
  wire [`SAT_DIV_W-1:0] halfCount;

  assign lastCount = divisor - 12'h001;
  assign halfCount = {1'b0, divisor[`SAT_DIV_W-1:1]};

  // A count already past a freshly lowered divisor also wraps, so a
  // divisor change never leaves the counter running up to overflow.
  assign terminal = (count_q >= lastCount);
  assign midpoint = (count_q == halfCount);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= `SAT_DIV_RST;
    end else if (restart || terminal) begin
      count_q <= `SAT_DIV_RST;
    end else begin
      count_q <= count_q + 12'h001;
    end
  end
endmodule // sat_baud_counter

//--- hdl/sat_rx_buffer.v
// Purpose: One-byte receive output buffer with valid and overrun flags.
// Assumes: store and readStrobe are single-cycle pulses.
// Notes:   A store in the same cycle as a read strobe wins over the clear.
`timescale 1ns/1ps
`include "sat_defines.vh"

module sat_rx_buffer (
  clk,
  arst_n,
  store,
  storeData,
  storeStop,
  storeParErr,
  readStrobe,
  rxData,
  rxValid,
  rxOverrun,
  frameError,
  parityError
);
  input  wire                   clk;
  input  wire                   arst_n;
  input  wire                   store;
  input  wire [`SAT_DATA_W-1:0] storeData;
  input  wire                   storeStop;
  input  wire                   storeParErr;
  input  wire                   readStrobe;
  output reg  [`SAT_DATA_W-1:0] rxData;
  output reg                    rxValid;
  output reg                    rxOverrun;
  output reg                    frameError;
  output reg                    parityError;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxData      <= 8'h00;
      rxValid     <= 1'b0;
      rxOverrun   <= 1'b0;
      frameError  <= 1'b0;
      parityError <= 1'b0;
    end else if (store) begin
      rxData      <= storeData;
      frameError  <= ~storeStop;
      parityError <= storeParErr;
      rxValid     <= 1'b1;
      rxOverrun   <= rxOverrun | rxValid;
    end else if (readStrobe) begin
      rxValid     <= 1'b0;
      rxOverrun   <= 1'b0;
    end
  end
endmodule // sat_rx_buffer

//--- dv/sat_uart_chk.sv
// Purpose: Port-level assertions for sat_uart.
// Assumes: Bound to every sat_uart instance; divisors of six or more.
// Notes:   Bit periods vary at run time, so only the six-clock start-bit floor and an eight-clock busy floor are timed.
`timescale 1ns/1ps
module sat_uart_chk (
  input wire clk,
  input wire arst_n,
  input wire parityEnable,
  input wire txWrite,
  input wire txIdle,
  input wire txd,
  input wire rxRead,
  input wire rxValid,
  input wire rxOverrun,
  input wire frameError,
  input wire parityError
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_idleHigh; txIdle |-> txd; endproperty
  a_idleHigh: assert property (p_idleHigh) else $error("txd low while idle");
  property p_start; txWrite |=> (!txIdle && !txd) [*6]; endproperty
  a_start: assert property (p_start) else $error("start bit short");
  property p_busy; txWrite |=> !txIdle [*8]; endproperty
  a_busy: assert property (p_busy) else $error("idle too soon");
  property p_idleHold; txIdle && !txWrite |=> txIdle; endproperty
  a_idleHold: assert property (p_idleHold) else $error("idle dropped");
  property p_stopEnd; $rose(txIdle) |-> txd && $past(txd, 1); endproperty
  a_stopEnd: assert property (p_stopEnd) else $error("frame ended low");
  property p_validHold; rxValid && !rxRead |=> rxValid; endproperty
  a_validHold: assert property (p_validHold) else $error("valid lost");
  property p_ovrCause; $rose(rxOverrun) |-> $past(rxValid); endproperty
  a_ovrCause: assert property (p_ovrCause) else $error("overrun cause");
  property p_readClr; rxRead |=> !rxOverrun || $past(rxValid); endproperty
  a_readClr: assert property (p_readClr) else $error("overrun kept");
  property p_frameUpd; $changed(frameError) |-> rxValid; endproperty
  a_frameUpd: assert property (p_frameUpd) else $error("frame flag moved");
  property p_parRose; $rose(parityError) |-> parityEnable && rxValid; endproperty
  a_parRose: assert property (p_parRose) else $error("parity flag cause");
endmodule // sat_uart_chk

bind sat_uart sat_uart_chk sat_uart_chk_i (.clk(clk), .arst_n(arst_n), .parityEnable(parityEnable),
  .txWrite(txWrite), .txIdle(txIdle), .txd(txd), .rxRead(rxRead), .rxValid(rxValid),
  .rxOverrun(rxOverrun), .frameError(frameError), .parityError(parityError));

//--- dv/sat_line_model.sv
// Purpose: Remote serial station: sends frames on rxd and decodes txd.
// Assumes: div equals the divisor the block uses.
// Notes:   Eleven bit times are always sent; without parity the last is idle high, with parity it is the stop bit, so parity frames abut.
`timescale 1ns/1ps
module sat_line_model (
  input  wire        clk,
  input  wire [11:0] div,
  input  wire        txd,
  output reg         rxd
);
  initial rxd = 1'b1;
  task automatic sendFrame(input [7:0] d, input pe, input po, input bad);
    reg [10:0] f;
    begin
      f = pe ? {1'b1, po ^ (^d) ^ bad, d, 1'b0} : {1'b1, !bad, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
        rxd <= f[i];
        repeat (div) @(posedge clk);
      end
    end
  endtask
  task automatic grabFrame(output [10:0] f);
    begin
      while (txd) @(posedge clk);
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 11; i++) begin
        f[i] = txd;
        repeat (div) @(posedge clk);
      end
    end
  endtask
endmodule // sat_line_model

//--- dv/tb_sat_uart.sv
// Purpose: Self-checking bench for sat_uart in both forms.
// Assumes: 40 MHz clock; divisors of six or more.
// Notes:   The minimal form shares every input and is judged on its fixed timing.
`timescale 1ns/1ps
`include "sat_defines.vh"
module tb_sat_uart;
  reg         clk, arst_n, parityEnable, parityOdd, twoStopBits, txWrite, rxRead;
  reg  [11:0] baudDiv;
  reg  [7:0]  txByte;
  wire [7:0]  rxData, minData;
  wire        txIdle, txd, rxd, rxValid, rxOverrun, frameError, parityError, minTxd, minIdle, minValid;
  wire [2:0]  watched = {minIdle, minTxd, txIdle};
  integer     fail_count = 0, compares = 0, cycles = 0;
  sat_uart #(.ENHANCED(1)) sat_uart_i (.clk(clk), .arst_n(arst_n), .baudDiv(baudDiv),
    .parityEnable(parityEnable), .parityOdd(parityOdd), .twoStopBits(twoStopBits), .txWrite(txWrite),
    .txByte(txByte), .txIdle(txIdle), .txd(txd), .rxd(rxd), .rxRead(rxRead), .rxData(rxData),
    .rxValid(rxValid), .rxOverrun(rxOverrun), .frameError(frameError), .parityError(parityError));
  sat_uart #(.ENHANCED(0)) sat_uart_min_i (.clk(clk), .arst_n(arst_n), .baudDiv(baudDiv),
    .parityEnable(parityEnable), .parityOdd(parityOdd), .twoStopBits(twoStopBits), .txWrite(txWrite),
    .txByte(txByte), .txIdle(minIdle), .txd(minTxd), .rxd(rxd), .rxRead(rxRead), .rxData(minData),
    .rxValid(minValid), .rxOverrun(), .frameError(), .parityError());
  sat_line_model sat_line_model_i (.clk(clk), .div(baudDiv), .txd(txd), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report;
    end
  end
  task final_report;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task automatic check(input string what, input [15:0] exp, input [15:0] got);
    begin
      compares++;
      if (got !== exp) begin
        $display("wrong value %s expected %h seen %h", what, exp, got);
        fail_count++;
      end
    end
  endtask
  task automatic sendTx(input [7:0] d);
    begin
      txByte <= d;
      txWrite <= 1'b1;
      @(posedge clk);
      txWrite <= 1'b0;
    end
  endtask
  // Counts the edges at which the selected output (0 txIdle, 1 minTxd, 2 minIdle) is still low.
  task automatic countLow(input integer sel, output integer n);
    begin
      n = 0;
      @(posedge clk);
      while (!watched[sel] && n < 4000) begin
        n++;
        @(posedge clk);
      end
    end
  endtask
  task automatic pulseRead;
    begin
      rxRead <= 1'b1;
      @(posedge clk);
      rxRead <= 1'b0;
      repeat (2) @(posedge clk);
      check("rxFlags", 16'h0000, {14'h0, rxValid, rxOverrun});
    end
  endtask
  task automatic t_txFrames(input [11:0] dv);
    reg [10:0] f, e;
    reg [7:0]  d;
    integer    n;
    begin
      baudDiv <= dv;
      for (int i = 0; i < 8; i++) begin
        d = 8'h3c + 8'(i * 41);
        {twoStopBits, parityOdd, parityEnable} <= i[2:0];
        @(posedge clk);
        sendTx(d);
        fork
          sat_line_model_i.grabFrame(f);
          countLow(0, n);
        join
        e = i[0] ? {1'b1, i[1] ^ (^d), d, 1'b0} : {2'b11, d, 1'b0};
        check("txFrame", {5'h0, e}, {5'h0, f});
        check("txBusy", 16'((10 + i[2] + i[0]) * dv), n[15:0]);
      end
    end
  endtask
  task automatic t_rxFrames;
    reg [7:0] d;
    begin
      for (int i = 0; i < 8; i++) begin
        d = 8'hc3 ^ 8'(i * 37);
        {parityOdd, parityEnable} <= i[1:0];
        @(posedge clk);
        sat_line_model_i.sendFrame(d, i[0], i[1], i[2]);
        // A parity frame is stored on the very edge at which the model returns.
        repeat (2) @(posedge clk);
        check("rxData", {8'h0, d}, {8'h0, rxData});
        check("rxValid", 16'h0001, {15'h0, rxValid});
        check("frameError", {15'h0, !i[0] && i[2]}, {15'h0, frameError});
        check("parityError", {15'h0, i[0] && i[2]}, {15'h0, parityError});
        pulseRead;
      end
    end
  endtask
  task automatic t_overrun;
    begin
      parityEnable <= 1'b0;
      sat_line_model_i.sendFrame(8'h5a, 1'b0, 1'b0, 1'b0);
      sat_line_model_i.sendFrame(8'ha5, 1'b0, 1'b0, 1'b0);
      check("overrun", 16'h03a5, {6'h0, rxValid, rxOverrun, rxData});
      pulseRead;
    end
  endtask
  task automatic t_minimal;
    integer n;
    begin
      twoStopBits <= 1'b0;
      @(posedge clk);
      sendTx(8'hff);
      countLow(1, n);
      check("minStart", {4'h0, `SAT_DIV_FIXED}, n[15:0]);
      countLow(2, n);
      // The edge at which the first count saw the line rise is counted by neither call.
      check("minFrame", 16'(9 * `SAT_DIV_FIXED - 1), n[15:0]);
      // Let the fixed-rate receiver flush whatever it made of the faster frames.
      baudDiv <= `SAT_DIV_FIXED;
      repeat (11 * `SAT_DIV_FIXED) @(posedge clk);
      pulseRead;
      sat_line_model_i.sendFrame(8'h96, 1'b0, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      check("minRx", 16'h0196, {7'h0, minValid, minData});
      pulseRead;
    end
  endtask
  initial begin
    arst_n = 1'b0;
    {parityEnable, parityOdd, twoStopBits, txWrite, rxRead} = 5'h00;
    baudDiv = 12'h008;
    txByte = 8'h00;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check("resetState", 16'h00c0, {8'h0, txIdle, txd, rxValid, rxOverrun, frameError, parityError, 2'h0});
    t_txFrames(12'h006);
    t_txFrames(12'h009);
    baudDiv <= 12'h008;
    t_rxFrames;
    t_overrun;
    t_minimal;
    final_report;
  end
endmodule // tb_sat_uart
